// ===== include/uetf_consts.svh
// Offsets, field positions, reset values and sizes of the endpoint 4 transmit FIFO block.
// Assumes a 16-bit register address and byte-wide register data.
`ifndef UETF_CONSTS_SVH
`define UETF_CONSTS_SVH
`define UETF_OFS_TX_DATA 16'h4028
`define UETF_OFS_TX_COUNT 16'h402A
`define UETF_OFS_TX_STATUS 16'h402C
`define UETF_OFS_EP3_MPS 16'h4026
`define UETF_OFS_EP4_MPS 16'h402E
`define UETF_OFS_REVISION 16'h4030
`define UETF_BIT_EMPTY 0
`define UETF_BIT_FULL 1
`define UETF_BIT_OVERFLOW 3
`define UETF_BIT_FLUSH 4
`define UETF_BIT_VALID 5
`define UETF_MPS_RESET 8'h08
`define UETF_FIFO_DEPTH 64
`define UETF_REVISION_DEFAULT 8'h5A
`endif

// ===== include/uetf_pkg.sv
// Types shared by the endpoint 4 transmit FIFO block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package uetf_pkg;
	typedef logic [7:0] uetf_byte_t;
endpackage
`default_nettype wire

// ===== core/uetf_ep4_tx_fifo.sv
// Endpoint 4 transmit FIFO with count, status and packet size registers.
// Assumes a plain register port and a USB engine that pops one byte per request.
//
// Notes on behaviour
// - CPU byte writes to the data register push into the transmit FIFO
// - Host IN reads on endpoint 4 pop queued bytes to the USB engine
// - Count register reports valid entries from zero up to sixty-four
// - Endpoint 3 packet size counts eight-byte units, resets to sixty-four bytes
// - Endpoint 4 packet size is read/write in eight-byte units, resets 08h
// - Endpoint 3 packet size is presented to the descriptor logic
// - Endpoint 4 packet size is presented to the descriptor logic
// - Revision register is read-only; writes change nothing
//
// The strobed register port was left to the implementer.
`include "uetf_consts.svh"
`default_nettype none
module uetf_ep4_tx_fifo
	import uetf_pkg::*;
#(
	parameter int DEPTH = `UETF_FIFO_DEPTH,
	parameter logic [7:0] REVISION = `UETF_REVISION_DEFAULT // Arbitrary value
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic in_pop,
	output logic [7:0] in_data,
	output logic in_data_valid,
	output logic in_ready,
	output logic [7:0] ep3_mps,
	output logic [7:0] ep4_mps
);
	localparam int AW = $clog2(DEPTH);

	uetf_byte_t mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic overflow_q;
	logic valid_q;
	logic [7:0] ep3_mps_q;
	logic [7:0] ep4_mps_q;
	logic [7:0] rdata_q;
	logic [7:0] in_data_q;
	logic in_data_valid_q;
	logic in_ready_q;

	wire fifo_full = (count_q == (AW+1)'(DEPTH));
	wire fifo_empty = (count_q == '0);
	wire sel_data = (reg_addr == `UETF_OFS_TX_DATA);
	wire sel_count = (reg_addr == `UETF_OFS_TX_COUNT);
	wire sel_status = (reg_addr == `UETF_OFS_TX_STATUS);
	wire sel_ep3 = (reg_addr == `UETF_OFS_EP3_MPS);
	wire sel_ep4 = (reg_addr == `UETF_OFS_EP4_MPS);
	wire sel_rev = (reg_addr == `UETF_OFS_REVISION);
	wire wr_data = reg_wr && sel_data;
	wire wr_status = reg_wr && sel_status;
	wire do_flush = wr_status && reg_wdata[`UETF_BIT_FLUSH];
	// Writes while full are dropped rather than wrapping over unsent bytes
	wire do_push = wr_data && !fifo_full && !do_flush;
	// Host may only drain once software has marked the data valid
	wire do_pop = in_pop && valid_q && !fifo_empty && !do_flush;
	wire [7:0] status_word = {2'b00, valid_q, 1'b0, overflow_q, 1'b0,
		fifo_full, fifo_empty};
	wire [7:0] rd_mux =
		sel_count ? 8'(count_q) :
		sel_status ? status_word :
		sel_ep3 ? ep3_mps_q :
		sel_ep4 ? ep4_mps_q :
		sel_rev ? REVISION :
		8'h00;
	wire last_pop = do_pop && (count_q == (AW+1)'(1));

	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem[wr_ptr_q] <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst || do_flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			wr_ptr_q <= do_push ? wr_ptr_q + AW'(1) : wr_ptr_q;
			rd_ptr_q <= do_pop ? rd_ptr_q + AW'(1) : rd_ptr_q;
			count_q <= count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			overflow_q <= 1'b0;
		end else if (wr_data && fifo_full) begin
			overflow_q <= 1'b1;
		end else if (wr_status && reg_wdata[`UETF_BIT_OVERFLOW]) begin
			overflow_q <= 1'b0;
		end
	end

	// Draining the last byte clears valid even if software sets it that cycle
	always_ff @(posedge ref_clk) begin
		if (srst || do_flush) begin
			valid_q <= 1'b0;
		end else if (last_pop) begin
			valid_q <= 1'b0;
		end else if (wr_status && reg_wdata[`UETF_BIT_VALID]) begin
			valid_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ep3_mps_q <= `UETF_MPS_RESET;
			ep4_mps_q <= `UETF_MPS_RESET;
		end else begin
			ep3_mps_q <= (reg_wr && sel_ep3) ? reg_wdata : ep3_mps_q;
			ep4_mps_q <= (reg_wr && sel_ep4) ? reg_wdata : ep4_mps_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			in_data_q <= 8'h00;
			in_data_valid_q <= 1'b0;
			in_ready_q <= 1'b0;
		end else begin
			in_data_q <= do_pop ? mem[rd_ptr_q] : in_data_q;
			in_data_valid_q <= do_pop;
			in_ready_q <= valid_q && !fifo_empty && !do_flush && !last_pop;
		end
	end

	assign reg_rdata = rdata_q;
	assign in_data = in_data_q;
	assign in_data_valid = in_data_valid_q;
	assign in_ready = in_ready_q;
	assign ep3_mps = ep3_mps_q;
	assign ep4_mps = ep4_mps_q;

	// Push side: count, storage and pointer move together
	a_push_counts: assert property (@(posedge ref_clk) disable iff (srst)
		(do_push && !do_pop) |=> count_q == $past(count_q) + 1)
		else $error("push did not raise count");

	a_push_stores: assert property (@(posedge ref_clk) disable iff (srst)
		do_push |=> mem[$past(wr_ptr_q)] == $past(reg_wdata))
		else $error("pushed byte not stored");

	a_push_moves_ptr: assert property (@(posedge ref_clk) disable iff (srst)
		do_push |=> wr_ptr_q == $past(wr_ptr_q) + AW'(1))
		else $error("write pointer did not advance");

	a_full_drops: assert property (@(posedge ref_clk) disable iff (srst)
		(wr_data && fifo_full && !do_pop) |=> $stable(count_q))
		else $error("write while full changed count");

	a_data_reads_zero: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && sel_data) |=> reg_rdata == 8'h00)
		else $error("write only data register read back");

	// Pop side: a byte leaves only on an accepted request
	a_pop_delivers: assert property (@(posedge ref_clk) disable iff (srst)
		do_pop |=> in_data_valid && in_data == $past(mem[rd_ptr_q]))
		else $error("pop did not deliver byte");

	a_pop_counts: assert property (@(posedge ref_clk) disable iff (srst)
		(do_pop && !do_push) |=> count_q == $past(count_q) - 1)
		else $error("pop did not lower count");

	a_pop_moves_ptr: assert property (@(posedge ref_clk) disable iff (srst)
		do_pop |=> rd_ptr_q == $past(rd_ptr_q) + AW'(1))
		else $error("read pointer did not advance");

	a_empty_refused: assert property (@(posedge ref_clk) disable iff (srst)
		(in_pop && fifo_empty) |=> !in_data_valid)
		else $error("pop from empty delivered data");

	a_valid_pulse: assert property (@(posedge ref_clk) disable iff (srst)
		in_data_valid |-> $past(do_pop))
		else $error("data strobe without pop");

	a_data_holds: assert property (@(posedge ref_clk) disable iff (srst)
		!do_pop |=> $stable(in_data))
		else $error("host data changed without pop");

	// Count register
	a_count_bound: assert property (@(posedge ref_clk) disable iff (srst)
		count_q <= (AW+1)'(DEPTH))
		else $error("count above depth");

	a_count_idle: assert property (@(posedge ref_clk) disable iff (srst)
		(!do_push && !do_pop && !do_flush) |=> $stable(count_q))
		else $error("count moved while idle");

	a_count_reads: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && sel_count) |=> reg_rdata == 8'($past(count_q)))
		else $error("count read wrong");

	a_rdata_idle: assert property (@(posedge ref_clk) disable iff (srst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read");

	// Flush beats any push or pop in the same cycle
	a_flush_empties: assert property (@(posedge ref_clk) disable iff (srst)
		do_flush |=> count_q == 0 && !valid_q)
		else $error("flush left data");

	a_flush_ptrs: assert property (@(posedge ref_clk) disable iff (srst)
		do_flush |=> wr_ptr_q == '0 && rd_ptr_q == '0)
		else $error("flush left pointers");

	a_flush_no_pop: assert property (@(posedge ref_clk) disable iff (srst)
		do_flush |=> !in_data_valid)
		else $error("pop accepted during flush");

	a_flush_reads_zero: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && sel_status) |=> reg_rdata[`UETF_BIT_FLUSH] == 1'b0)
		else $error("flush bit read back set");

	// Status flags
	a_flags_track: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && sel_status) |=> reg_rdata[1:0] == $past({fifo_full, fifo_empty}))
		else $error("full or empty flag wrong");

	a_status_spare: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && sel_status) |=> reg_rdata[7:6] == 2'b00 && reg_rdata[2] == 1'b0)
		else $error("spare status bits set");

	// Packet size and revision registers
	a_ep4_reset: assert property (@(posedge ref_clk)
		$fell(srst) |-> ep4_mps == `UETF_MPS_RESET && ep3_mps == `UETF_MPS_RESET)
		else $error("packet size reset wrong");

	a_ep3_write: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_wr && sel_ep3) |=> ep3_mps == $past(reg_wdata))
		else $error("endpoint 3 size not written");

	a_ep3_hold: assert property (@(posedge ref_clk) disable iff (srst)
		!(reg_wr && sel_ep3) |=> $stable(ep3_mps))
		else $error("endpoint 3 size changed");

	a_ep3_reads: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && sel_ep3) |=> reg_rdata == $past(ep3_mps_q))
		else $error("endpoint 3 size read wrong");

	a_ep4_write: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_wr && sel_ep4) |=> ep4_mps == $past(reg_wdata))
		else $error("endpoint 4 size not written");

	a_ep4_hold: assert property (@(posedge ref_clk) disable iff (srst)
		!(reg_wr && sel_ep4) |=> $stable(ep4_mps))
		else $error("endpoint 4 size changed");

	a_ep4_reads: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && sel_ep4) |=> reg_rdata == $past(ep4_mps_q))
		else $error("endpoint 4 size read wrong");

	a_rev_fixed: assert property (@(posedge ref_clk) disable iff (srst)
		(reg_rd && sel_rev) |=> reg_rdata == REVISION)
		else $error("revision read wrong");

	// Valid bit gates the host side
	a_valid_clears: assert property (@(posedge ref_clk) disable iff (srst)
		last_pop |=> !valid_q ##1 !in_ready)
		else $error("valid not cleared after drain");

	a_valid_sets: assert property (@(posedge ref_clk) disable iff (srst)
		(wr_status && reg_wdata[`UETF_BIT_VALID] && !do_flush && !last_pop) |=> valid_q)
		else $error("valid not set");

	a_pop_refused: assert property (@(posedge ref_clk) disable iff (srst)
		(in_pop && !valid_q) |=> !in_data_valid)
		else $error("pop accepted without valid");

	a_ready_needs_valid: assert property (@(posedge ref_clk) disable iff (srst)
		in_ready |-> $past(valid_q))
		else $error("ready without valid");

	a_ready_drops: assert property (@(posedge ref_clk) disable iff (srst)
		fifo_empty |=> !in_ready)
		else $error("ready while empty");

	// Overflow is sticky until software writes a one to it
	a_overflow_sets: assert property (@(posedge ref_clk) disable iff (srst)
		(wr_data && fifo_full) |=> overflow_q)
		else $error("overflow not set");

	a_overflow_holds: assert property (@(posedge ref_clk) disable iff (srst)
		(overflow_q && !(wr_status && reg_wdata[`UETF_BIT_OVERFLOW])) |=> overflow_q)
		else $error("overflow lost without clear");

	a_overflow_clears: assert property (@(posedge ref_clk) disable iff (srst)
		(wr_status && reg_wdata[`UETF_BIT_OVERFLOW]) |=> !overflow_q)
		else $error("overflow not cleared");

	c_fill_full: cover property (@(posedge ref_clk) disable iff (srst) fifo_full);
	c_overflow: cover property (@(posedge ref_clk) disable iff (srst) wr_data && fifo_full);
	c_drain: cover property (@(posedge ref_clk) disable iff (srst) last_pop);
	c_flush: cover property (@(posedge ref_clk) disable iff (srst) do_flush && !fifo_empty);
	c_overflow_clear: cover property (@(posedge ref_clk) disable iff (srst) overflow_q ##1 !overflow_q);
endmodule
`default_nettype wire

// ===== tb/uetf_host_model.sv
// USB engine model that pops endpoint 4 bytes at a rate the bench varies.
// Assumes ready lags a cycle, so a spare pop may reach an empty FIFO.
`default_nettype none
module uetf_host_model (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic go,
	input wire logic in_ready,
	output logic in_pop
);
	timeunit 1ns;
	timeprecision 1ps;
	// Slow host is modelled by the bench dropping go at random
	always_ff @(posedge ref_clk) begin
		in_pop <= !srst && go && in_ready;
	end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Bench for the endpoint 4 transmit FIFO, checked against a queue model.
// Assumes the host model for pops; revision is overridden per instance.
`include "uetf_consts.svh"
`default_nettype none
module tb_top;
	import uetf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] REV = 8'h3C; // Arbitrary value
	localparam logic [15:0] ST = `UETF_OFS_TX_STATUS;
	localparam logic [15:0] CNT = `UETF_OFS_TX_COUNT;
	logic ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, go = 0, run = 0;
	logic in_pop, in_data_valid, in_ready;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, in_data, ep3_mps, ep4_mps, d;
	int mismatches = 0, num_checks = 0, cyc = 0;
	logic [7:0] q[$];
	uetf_ep4_tx_fifo #(.REVISION(REV)) uetf_ep4_tx_fifo_inst (.ref_clk(ref_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_pop(in_pop), .in_data(in_data),
		.in_data_valid(in_data_valid), .in_ready(in_ready), .ep3_mps(ep3_mps), .ep4_mps(ep4_mps));
	uetf_host_model uetf_host_model_inst (.ref_clk(ref_clk), .srst(srst), .go(go),
		.in_ready(in_ready), .in_pop(in_pop));
	always #5 ref_clk = ~ref_clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// A write while full is dropped by the model too
	task automatic push(input logic [7:0] v);
		wr(`UETF_OFS_TX_DATA, v);
		if (q.size() < `UETF_FIFO_DEPTH) q.push_back(v);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		go <= run && ($urandom % 2 == 0);
		if (in_data_valid === 1'b1) chk(in_data, q.pop_front());
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		void'($urandom(46));
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		rd(`UETF_OFS_EP4_MPS, `UETF_MPS_RESET);
		rd(`UETF_OFS_EP3_MPS, `UETF_MPS_RESET);
		rd(CNT, 8'h00);
		rd(ST, 8'h01);
		wr(`UETF_OFS_REVISION, ~REV);
		rd(`UETF_OFS_REVISION, REV);
		rd(`UETF_OFS_TX_DATA, 8'h00);
		rd(16'h4040, 8'h00);
		$display("test reset done");
		for (int i = 0; i <= `UETF_FIFO_DEPTH; i++) push(8'($urandom));
		rd(CNT, 8'h40);
		rd(ST, 8'h0A);
		wr(ST, 8'h08);
		rd(ST, 8'h02);
		$display("test fill done");
		run <= 1'b1;
		wr(ST, 8'h20);
		for (int i = 0; i < 1000 && q.size() > 0; i++) @(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
		rd(CNT, 8'h00);
		rd(ST, 8'h01);
		$display("test drain done");
		for (int i = 0; i < 3; i++) push(8'($urandom));
		wr(ST, 8'h10);
		q.delete();
		rd(CNT, 8'h00);
		rd(ST, 8'h01);
		$display("test flush done");
		d = 8'($urandom);
		wr(`UETF_OFS_EP4_MPS, d);
		#1 chk(ep4_mps, d);
		rd(`UETF_OFS_EP4_MPS, d);
		wr(`UETF_OFS_EP3_MPS, ~d);
		#1 chk(ep3_mps, ~d);
		rd(`UETF_OFS_EP3_MPS, ~d);
		$display("test packet size done");
		conclude();
	end
endmodule
`default_nettype wire
